// File: disk_param_pkg.sv
package disk_param_pkg;
  // -----------------------------------------------------------------
  // register byte offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] OFS_MAIN_STATUS = 8'h00; // select line low
  localparam logic [7:0] OFS_DATA = 8'h04; // select line high
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_PARAMS = 8'h0c;
  localparam logic [7:0] OFS_COMMAND = 8'h10;
  localparam logic [7:0] OFS_CYLINDER = 8'h14;
  localparam int SEL_LINE_BIT = 2; // address bit acting as select line
  // -----------------------------------------------------------------
  // config field positions
  // -----------------------------------------------------------------
  localparam int CFG_STEP_LSB = 0; // step_interval_code [3:0]
  localparam int CFG_DRV_LSB = 4; // drive_select [5:4]
  localparam int CFG_NODMA_BIT = 6; // no_dma_flag
  localparam int CFG_SKIP_BIT = 7; // skip_deleted_flag
  localparam int CFG_STRIDE_LSB = 8; // scan_sector_stride [9:8]
  localparam logic [9:0] CFG_RESET = 10'h000;
  // -----------------------------------------------------------------
  // params field positions
  // -----------------------------------------------------------------
  localparam int PAR_TCYL_LSB = 0; // target_cylinder
  localparam int PAR_REC_LSB = 8; // record (sector number)
  localparam int PAR_LAST_LSB = 16; // last_sector_number
  localparam int PAR_SIZE_LSB = 24; // sector size code [26:24]
  localparam logic [26:0] PAR_RESET = 27'h0000000;
  // -----------------------------------------------------------------
  // command codes
  // -----------------------------------------------------------------
  localparam logic [2:0] CMD_SEEK = 3'h1;
  localparam logic [2:0] CMD_READ = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h3;
  localparam logic [2:0] CMD_SCAN = 3'h4;
  localparam logic [2:0] CMD_SENSE = 3'h5;
  // -----------------------------------------------------------------
  // timing and counts
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int STEP_UNIT_NS = 1000000; // 1 ms per code step
  localparam int STEP_UNIT_CYC = STEP_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [4:0] STEP_MAX_MS = 5'h10; // code 0 -> 16 ms
  localparam logic [15:0] SECTOR_BASE_BYTES = 16'h0080; // size code 0
  localparam logic [2:0] RES_LEN_RW = 3'h4;
  localparam logic [2:0] RES_LEN_SENSE = 3'h2;
  // -----------------------------------------------------------------
  // sequencer states
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEEK = 3'b001,
    ST_LOCATE = 3'b011,
    ST_XFER = 3'b010,
    ST_RESULT = 3'b110
  } seq_e;
endpackage

// File: disk_command_parameter_decode.sv
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ns
module disk_command_parameter_decode
  import disk_param_pkg::*;
#(
  parameter int STEP_UNIT_CYCLES = STEP_UNIT_CYC // cycles per ms
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic disk_id_tgl, // toggles per sector id seen
  input wire logic [7:0] disk_id_sector,
  input wire logic disk_id_deleted,
  input wire logic disk_byte_tgl, // toggles per data byte slot
  input wire logic [7:0] disk_rd_byte,
  output logic [3:0] drive_sel_o,
  output logic [3:0] step_o,
  output logic dir_o,
  output logic [7:0] disk_wr_byte_o,
  output logic disk_wr_tgl_o,
  output logic dma_req_o,
  output logic data_ready_o
);
  import disk_param_pkg::*;

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  seq_e state_ff; // sequencer state
  logic [9:0] cfg_ff; // config register
  logic [26:0] par_ff; // command parameters
  logic [2:0] cmd_ff; // command in progress
  logic [7:0] cur_cyl_ff; // current_cylinder
  logic [7:0] rec_ff; // sector being sought
  logic [15:0] byte_cnt_ff; // bytes left in sector
  logic [23:0] step_cnt_ff; // step spacing timer
  logic [7:0] hold_ff; // data holding byte
  logic hold_full_ff; // holding byte valid
  logic overrun_ff; // data late
  logic mismatch_ff; // scan compare failed
  logic deleted_ff; // deleted mark seen on sought sector
  logic eot_ff; // ended at last sector
  logic seek_end_ff; // seek finished, awaiting sense
  logic [7:0] res_ff [4]; // result bytes
  logic [2:0] res_len_ff; // result bytes to read
  logic [2:0] res_idx_ff; // next result byte
  logic [2:0] id_sync_ff; // id toggle sync and history
  logic [2:0] byte_sync_ff; // byte toggle sync and history
  logic [8:0] id_meta_ff; // id fields, first stage
  logic [8:0] id_dat_ff; // id fields, second stage
  logic [7:0] rd_meta_ff; // read byte, first stage
  logic [7:0] rd_dat_ff; // read byte, second stage
  logic acc; // apb access with answer
  logic wr_acc; // write takes effect
  logic rd_acc; // read completes
  logic cmd_go; // command accepted
  logic id_evt; // sector id arrived
  logic byte_evt; // data byte slot arrived
  logic id_hit; // id matches record
  logic sec_done; // last byte of sector
  logic at_last; // record equals last sector
  logic [7:0] rec_step; // record increment
  logic [4:0] step_ms; // step spacing in ms
  logic host_fills; // host supplies bytes
  logic [31:0] rd_mux; // read data selection

  // -----------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------
  assign acc = psel && penable && pready;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;
  assign cmd_go = wr_acc && paddr == OFS_COMMAND && state_ff == ST_IDLE;
  assign host_fills = cmd_ff == CMD_WRITE || cmd_ff == CMD_SCAN;
  // inverse code: 16 - code, so f gives 1 ms
  assign step_ms = STEP_MAX_MS - {1'b0, cfg_ff[CFG_STEP_LSB +: 4]};
  // scan with stride two skips alternate sectors
  assign rec_step = (cmd_ff == CMD_SCAN &&
                     cfg_ff[CFG_STRIDE_LSB +: 2] == 2'h2) ? 8'h02 : 8'h01;
  assign id_hit = id_dat_ff[7:0] == rec_ff;
  assign at_last = rec_ff == par_ff[PAR_LAST_LSB +: 8];
  // sector ends once all bytes moved and a read byte was taken
  assign sec_done = state_ff == ST_XFER && byte_cnt_ff == 16'h0000 &&
                    !(hold_full_ff && !host_fills);
  assign id_evt = id_sync_ff[1] ^ id_sync_ff[2];
  assign byte_evt = byte_sync_ff[1] ^ byte_sync_ff[2];

  // -----------------------------------------------------------------
  // apb answer, one wait state
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (psel && penable && !pready)
    begin
      pready <= 1'b1;
      prdata <= rd_mux;
      pslverr <= !(paddr == OFS_MAIN_STATUS || paddr == OFS_DATA ||
                   paddr == OFS_CONFIG || paddr == OFS_PARAMS ||
                   paddr == OFS_COMMAND || paddr == OFS_CYLINDER);
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // read mux; full address decode picks the register
  always_comb
  begin
    rd_mux = 32'h00000000;
    unique case (paddr)
      OFS_MAIN_STATUS:
        rd_mux = {27'h0000000, state_ff == ST_SEEK,
                  host_fills && state_ff != ST_IDLE, hold_full_ff,
                  state_ff == ST_RESULT, state_ff != ST_IDLE};
      OFS_DATA:
      begin
        if (state_ff == ST_RESULT)
          rd_mux = {24'h000000, res_ff[res_idx_ff[1:0]]};
        else
          rd_mux = {24'h000000, hold_ff};
      end
      OFS_CONFIG: rd_mux = {22'h000000, cfg_ff};
      OFS_PARAMS: rd_mux = {5'h00, par_ff};
      OFS_CYLINDER: rd_mux = {24'h000000, cur_cyl_ff};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // -----------------------------------------------------------------
  // software registers
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_ff <= CFG_RESET;
      par_ff <= PAR_RESET;
    end
    else if (wr_acc && paddr == OFS_CONFIG)
      cfg_ff <= pwdata[9:0];
    else if (wr_acc && paddr == OFS_PARAMS)
      par_ff <= pwdata[26:0];
  end

  // -----------------------------------------------------------------
  // pin synchronisers, two flops before use
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      id_sync_ff <= 3'h0;
      byte_sync_ff <= 3'h0;
      id_meta_ff <= 9'h000;
      id_dat_ff <= 9'h000;
      rd_meta_ff <= 8'h00;
      rd_dat_ff <= 8'h00;
    end
    else
    begin
      id_sync_ff <= {id_sync_ff[1:0], disk_id_tgl};
      byte_sync_ff <= {byte_sync_ff[1:0], disk_byte_tgl};
      id_meta_ff <= {disk_id_deleted, disk_id_sector};
      id_dat_ff <= id_meta_ff;
      rd_meta_ff <= disk_rd_byte;
      rd_dat_ff <= rd_meta_ff;
    end
  end

  // -----------------------------------------------------------------
  // command sequencer
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= ST_IDLE;
      cmd_ff <= 3'h0;
      rec_ff <= 8'h00;
      byte_cnt_ff <= 16'h0000;
      res_idx_ff <= 3'h0;
      res_len_ff <= 3'h0;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          if (cmd_go)
          begin
            cmd_ff <= pwdata[2:0];
            rec_ff <= par_ff[PAR_REC_LSB +: 8];
            res_idx_ff <= 3'h0;
            if (pwdata[2:0] == CMD_SEEK)
              state_ff <= ST_SEEK;
            else if (pwdata[2:0] == CMD_SENSE)
            begin
              res_len_ff <= RES_LEN_SENSE;
              state_ff <= ST_RESULT;
            end
            else if (pwdata[2:0] == CMD_READ || pwdata[2:0] == CMD_WRITE ||
                     pwdata[2:0] == CMD_SCAN)
              state_ff <= ST_LOCATE;
          end
        end
        ST_SEEK:
        begin
          // done once head sits on the target
          if (cur_cyl_ff == par_ff[PAR_TCYL_LSB +: 8])
            state_ff <= ST_IDLE;
        end
        ST_LOCATE:
        begin
          if (id_evt && id_hit)
          begin
            // deleted mark with skip set: pass over it
            if (id_dat_ff[8] && cfg_ff[CFG_SKIP_BIT])
            begin
              rec_ff <= rec_ff + rec_step;
              if (at_last)
              begin
                res_len_ff <= RES_LEN_RW;
                state_ff <= ST_RESULT;
              end
            end
            else
            begin
              byte_cnt_ff <= SECTOR_BASE_BYTES <<
                             par_ff[PAR_SIZE_LSB +: 3];
              state_ff <= ST_XFER;
            end
          end
        end
        ST_XFER:
        begin
          if (byte_evt && byte_cnt_ff != 16'h0000)
            byte_cnt_ff <= byte_cnt_ff - 16'h0001;
          if (sec_done)
          begin
            rec_ff <= rec_ff + rec_step;
            if (at_last)
            begin
              res_len_ff <= RES_LEN_RW;
              state_ff <= ST_RESULT;
            end
            else
              state_ff <= ST_LOCATE;
          end
        end
        ST_RESULT:
        begin
          // each data read pops one result byte
          if (rd_acc && paddr == OFS_DATA)
          begin
            res_idx_ff <= res_idx_ff + 3'h1;
            if (res_idx_ff + 3'h1 == res_len_ff)
              state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // step timer and head position
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_cnt_ff <= 24'h000000;
      cur_cyl_ff <= 8'h00;
      step_o <= 4'h0;
      dir_o <= 1'b0;
    end
    else
    begin
      step_o <= 4'h0;
      if (state_ff != ST_SEEK)
        step_cnt_ff <= 24'h000000;
      else if (step_cnt_ff != 24'h000000)
        step_cnt_ff <= step_cnt_ff - 24'h000001;
      else if (cur_cyl_ff != par_ff[PAR_TCYL_LSB +: 8])
      begin
        // one pulse to the selected unit, then reload
        step_o[cfg_ff[CFG_DRV_LSB +: 2]] <= 1'b1;
        dir_o <= par_ff[PAR_TCYL_LSB +: 8] > cur_cyl_ff;
        step_cnt_ff <= 24'(step_ms * STEP_UNIT_CYCLES) -
                       24'h000001;
        if (par_ff[PAR_TCYL_LSB +: 8] > cur_cyl_ff)
          cur_cyl_ff <= cur_cyl_ff + 8'h01;
        else
          cur_cyl_ff <= cur_cyl_ff - 8'h01;
      end
    end
  end

  // drive select outputs, one-hot
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      drive_sel_o <= 4'h0;
    else
      drive_sel_o <= 4'h1 << cfg_ff[CFG_DRV_LSB +: 2];
  end

  // -----------------------------------------------------------------
  // data holding byte and transfer
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_ff <= 8'h00;
      hold_full_ff <= 1'b0;
      disk_wr_byte_o <= 8'h00;
      disk_wr_tgl_o <= 1'b0;
    end
    else if (state_ff != ST_XFER)
      hold_full_ff <= 1'b0;
    else if (byte_evt && byte_cnt_ff != 16'h0000 && !host_fills)
    begin
      // disk byte in wins over a same-cycle host read
      hold_ff <= rd_dat_ff;
      hold_full_ff <= 1'b1;
    end
    else if (byte_evt && byte_cnt_ff != 16'h0000)
    begin
      // write and scan consume the host byte
      if (cmd_ff == CMD_WRITE)
      begin
        disk_wr_byte_o <= hold_ff;
        disk_wr_tgl_o <= !disk_wr_tgl_o;
      end
      hold_full_ff <= 1'b0;
    end
    else if (wr_acc && paddr == OFS_DATA && host_fills)
    begin
      hold_ff <= pwdata[7:0];
      hold_full_ff <= 1'b1;
    end
    else if (rd_acc && paddr == OFS_DATA && !host_fills)
      hold_full_ff <= 1'b0;
  end

  // request outputs: dma or polled, never both
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_req_o <= 1'b0;
      data_ready_o <= 1'b0;
    end
    else
    begin
      // no host byte asked for once the sector count is spent
      dma_req_o <= state_ff == ST_XFER && !cfg_ff[CFG_NODMA_BIT] &&
                   (hold_full_ff ^ host_fills) &&
                   (byte_cnt_ff != 16'h0000 || hold_full_ff);
      data_ready_o <= state_ff == ST_XFER && cfg_ff[CFG_NODMA_BIT] &&
                      (hold_full_ff ^ host_fills) &&
                      (byte_cnt_ff != 16'h0000 || hold_full_ff);
    end
  end

  // -----------------------------------------------------------------
  // outcome flags and result bytes
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      overrun_ff <= 1'b0;
      mismatch_ff <= 1'b0;
      deleted_ff <= 1'b0;
      eot_ff <= 1'b0;
    end
    else if (cmd_go)
    begin
      overrun_ff <= 1'b0;
      mismatch_ff <= 1'b0;
      deleted_ff <= 1'b0;
      eot_ff <= 1'b0;
    end
    else
    begin
      if (state_ff == ST_XFER && byte_evt &&
          (hold_full_ff != host_fills))
        overrun_ff <= 1'b1;
      // byte-by-byte scan compare
      if (state_ff == ST_XFER && byte_evt && cmd_ff == CMD_SCAN &&
          hold_full_ff && hold_ff != rd_dat_ff)
        mismatch_ff <= 1'b1;
      if (state_ff == ST_LOCATE && id_evt && id_hit && id_dat_ff[8])
        deleted_ff <= 1'b1;
      if ((sec_done || state_ff == ST_LOCATE) && at_last)
        eot_ff <= 1'b1;
    end
  end

  // seek end flag; finishing seek wins over sense clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      seek_end_ff <= 1'b0;
    else if (state_ff == ST_SEEK &&
             cur_cyl_ff == par_ff[PAR_TCYL_LSB +: 8])
      seek_end_ff <= 1'b1;
    else if (cmd_go && pwdata[2:0] == CMD_SENSE)
      seek_end_ff <= 1'b0;
  end

  // result bytes: sense captured at command accept, others every cycle of locate and transfer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      res_ff[0] <= 8'h00;
      res_ff[1] <= 8'h00;
      res_ff[2] <= 8'h00;
      res_ff[3] <= 8'h00;
    end
    else if (cmd_go && pwdata[2:0] == CMD_SENSE)
    begin
      res_ff[0] <= {2'h0, seek_end_ff, 3'h0,
                    cfg_ff[CFG_DRV_LSB +: 2]};
      res_ff[1] <= cur_cyl_ff;
    end
    else if (state_ff != ST_RESULT && state_ff != ST_IDLE &&
             state_ff != ST_SEEK)
    begin
      res_ff[0] <= {6'h00, cfg_ff[CFG_DRV_LSB +: 2]};
      res_ff[1] <= {eot_ff, 3'h0, overrun_ff, 3'h0};
      res_ff[2] <= {1'b0, deleted_ff, 1'b0, 1'b0, mismatch_ff, 3'h0};
      res_ff[3] <= {3'h0, dir_o, 2'h0, cfg_ff[CFG_DRV_LSB +: 2]};
    end
  end
endmodule // disk_command_parameter_decode

// File: disk_param_chk.sv
`timescale 1ns/1ns
module disk_param_chk
  import disk_param_pkg::*;
#(
  parameter int STEP_UNIT_CYCLES = STEP_UNIT_CYC // cycles per ms
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] drive_sel_o,
  input wire logic [3:0] step_o,
  input wire logic dma_req_o,
  input wire logic data_ready_o
);
  // ---------
  // helper logic
  // ---------
  logic [9:0] cfg_ff; // shadow of config
  int gap_ff; // cycles since last step
  logic mapped; // address hits a register
  assign mapped = (paddr <= OFS_CYLINDER) && (paddr[1:0] == 2'h0);
  // track config writes at the completing edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_ff <= 10'h000;
    else if (psel && penable && pready && pwrite && paddr == OFS_CONFIG)
      cfg_ff <= pwdata[9:0];
  end
  // count from one step pulse to the next
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gap_ff <= 0;
    else if (|step_o)
      gap_ff <= 1;
    else if (gap_ff != 0 && gap_ff < 100000)
      gap_ff <= gap_ff + 1;
  end
  // ---------
  // assertions
  // ---------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not after one wait");
  a_ready_cause: assert property (pready |-> psel && penable && $past(psel && penable && !pready))
    else $error("pready without access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  a_err_zero_data: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error read data not zero");
  a_drive_onehot: assert property ($past(presetn) |-> $onehot(drive_sel_o))
    else $error("drive select not one-hot");
  a_step_on_sel: assert property (|step_o |-> step_o == drive_sel_o ##1 step_o == 4'h0)
    else $error("step pulse wrong drive or width");
  a_step_spacing: assert property (|step_o && gap_ff != 0 |-> gap_ff >= (16 - cfg_ff[3:0]) * STEP_UNIT_CYCLES)
    else $error("step pulses too close");
  a_dma_mode: assert property (dma_req_o |-> !cfg_ff[CFG_NODMA_BIT])
    else $error("dma request in no-dma mode");
  a_nodma_mode: assert property (data_ready_o |-> cfg_ff[CFG_NODMA_BIT])
    else $error("data ready in dma mode");
endmodule // disk_param_chk

// File: disk_drive_model.sv
`timescale 1ns/1ns
module disk_drive_model
#(
  parameter int BYTES = 128 // bytes per sector, size code 0
)(
  output logic id_tgl,
  output logic [7:0] id_sec,
  output logic id_del,
  output logic byte_tgl,
  output logic [7:0] rd_byte,
  input wire logic pclk
);
  // idle levels at time zero
  initial
  begin
    id_tgl = 1'b0;
    id_sec = 8'h00;
    id_del = 1'b0;
    byte_tgl = 1'b0;
    rd_byte = 8'h00;
  end
  // one sector: id, then a byte slot every 12 cycles
  task send_sector(input logic [7:0] s, input logic d);
    @(posedge pclk);
    id_sec <= s;
    id_del <= d;
    repeat (4) @(posedge pclk);
    id_tgl <= ~id_tgl;
    repeat (4) @(posedge pclk);
    id_sec <= ~s; // hold time over, show garbage
    id_del <= ~d;
    for (int i = 0; i < BYTES; i++)
    begin
      rd_byte <= 8'(i) ^ (s << 5);
      repeat (4) @(posedge pclk);
      byte_tgl <= ~byte_tgl;
      repeat (4) @(posedge pclk);
      rd_byte <= ~rd_byte; // no longer valid
      repeat (4) @(posedge pclk);
    end
  endtask
endmodule // disk_drive_model

// File: disk_command_parameter_decode_tb.sv
`timescale 1ns/1ns
module disk_command_parameter_decode_tb;
  import disk_param_pkg::*;
  localparam int UNIT = 4; // short ms for simulation
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic id_tgl, id_del, byte_tgl, dir, dma_req, data_rdy;
  logic [7:0] id_sec, rd_byte;
  logic [3:0] drive_sel, step;
  int bad_count, num_checks;
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  disk_command_parameter_decode #(.STEP_UNIT_CYCLES(UNIT))
  disk_command_parameter_decode_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .disk_id_tgl(id_tgl),
    .disk_id_sector(id_sec), .disk_id_deleted(id_del),
    .disk_byte_tgl(byte_tgl), .disk_rd_byte(rd_byte),
    .drive_sel_o(drive_sel), .step_o(step), .dir_o(dir),
    .disk_wr_byte_o(), .disk_wr_tgl_o(), .dma_req_o(dma_req),
    .data_ready_o(data_rdy)
  );
  disk_drive_model disk_drive_model_inst (
    .id_tgl(id_tgl), .id_sec(id_sec), .id_del(id_del),
    .byte_tgl(byte_tgl), .rd_byte(rd_byte), .pclk(pclk)
  );
  // ---------
  // shared tasks
  // ---------
  task conclude;
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task hang(input string w);
    $display("BAD %0t timeout %s", $time, w);
    bad_count++;
    conclude;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp, input string w);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  // apb transfer, read data and error left in rd and pslverr view
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      hang("apb");
    rd = {prdata[31:1], prdata[0]};
    rd[31] = (pslverr === 1'b1) ? ~rd[31] : rd[31]; // flag error in check
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task poll(input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, OFS_MAIN_STATUS, 32'h0);
      n++;
    end
    while (rd[b] !== v && n < 20000);
    if (n >= 20000)
      hang("status");
  endtask
  // ---------
  // scenarios
  // ---------
  task t_reset;
    repeat (2) @(posedge pclk);
    check(drive_sel, 4'h1, "drive after reset");
    apb(1'b0, OFS_CONFIG, 32'h0);
    check(rd, 32'h0, "config reset");
    apb(1'b0, OFS_PARAMS, 32'h0);
    check(rd, 32'h0, "params reset");
    apb(1'b0, OFS_CYLINDER, 32'h0);
    check(rd, 32'h0, "cylinder reset");
    apb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h80000000, "unmapped read");
  endtask
  task t_regs;
    apb(1'b1, OFS_CONFIG, 32'h2b5);
    apb(1'b0, OFS_CONFIG, 32'h0);
    check(rd, 32'h2b5, "config readback");
    apb(1'b1, OFS_PARAMS, 32'h5a3c1e7);
    apb(1'b0, OFS_PARAMS, 32'h0);
    check(rd, 32'h5a3c1e7, "params readback");
    for (int d = 0; d < 4; d++)
    begin
      apb(1'b1, OFS_CONFIG, 32'(d << 4));
      repeat (2) @(posedge pclk);
      check(drive_sel, 4'h1 << d, "drive select");
    end
  endtask
  task t_seek(input logic [3:0] c, input logic [1:0] dv,
    input logic [7:0] tg, input logic [7:0] fr);
    int n, st, last, want;
    want = (tg > fr) ? tg - fr : fr - tg;
    apb(1'b1, OFS_CONFIG, {26'h0, dv, c});
    apb(1'b1, OFS_PARAMS, {24'h0, tg});
    apb(1'b1, OFS_COMMAND, {29'h0, CMD_SEEK});
    n = 0;
    st = 0;
    last = 0;
    while (st < want && n < 2000)
    begin
      @(posedge pclk);
      n++;
      if (step !== 4'h0)
      begin
        check(step, 4'h1 << dv, "step drive");
        check(dir, tg > fr, "step direction");
        if (st > 0)
          check(n - last, (16 - c) * UNIT, "step gap");
        last = n;
        st++;
      end
    end
    if (st < want)
      hang("seek");
    poll(0, 1'b0);
    apb(1'b1, OFS_COMMAND, {29'h0, CMD_SENSE});
    poll(1, 1'b1);
    apb(1'b0, OFS_DATA, 32'h0);
    check(rd, {24'h0, 3'b001, 3'b000, dv}, "sense status");
    apb(1'b0, OFS_DATA, 32'h0);
    check(rd, {24'h0, tg}, "sense cylinder");
    apb(1'b0, OFS_CYLINDER, 32'h0);
    check(rd, {24'h0, tg}, "cylinder reg");
  endtask
  task t_read(input logic [2:0] cmd, input logic nd, input logic [1:0] dv);
    int k, n;
    logic [7:0] s, b;
    apb(1'b1, OFS_CONFIG, {22'h0, 2'h2, cmd == CMD_READ, nd, dv, 4'hf});
    apb(1'b1, OFS_PARAMS, {8'h0, 8'h03, 8'h01, 8'h00});
    apb(1'b1, OFS_COMMAND, {29'h0, cmd});
    k = 0;
    n = 0;
    fork
      begin
        disk_drive_model_inst.send_sector(8'h07, 1'b0);
        disk_drive_model_inst.send_sector(8'h01, 1'b0);
        disk_drive_model_inst.send_sector(8'h02, 1'b1);
        disk_drive_model_inst.send_sector(8'h03, 1'b0);
        disk_drive_model_inst.send_sector(8'h04, 1'b0);
      end
      while (k < 256 && n < 60000)
      begin
        @(posedge pclk);
        n++;
        if ((nd ? data_rdy : dma_req) === 1'b1)
        begin
          check(nd ? dma_req : data_rdy, 32'h0, "other req");
          s = (k < 128) ? 8'h01 : 8'h03;
          b = 8'(k % 128) ^ (s << 5);
          apb(cmd != CMD_READ, OFS_DATA, {24'h0, b});
          if (cmd == CMD_READ)
            check(rd, {24'h0, b}, "byte");
          k++;
          repeat (2) @(posedge pclk);
        end
      end
    join
    if (k < 256)
      hang("read");
    check(dma_req | data_rdy, 32'h0, "req after last");
    poll(1, 1'b1);
    apb(1'b0, OFS_DATA, 32'h0);
    check(rd, {30'h0, dv}, "result byte 0");
    apb(1'b0, OFS_DATA, 32'h0);
    check(rd, 32'h80, "st1");
    apb(1'b0, OFS_DATA, 32'h0);
    check(rd, {25'h0, cmd == CMD_READ, 6'h0}, "st2");
    apb(1'b0, OFS_DATA, 32'h0);
    apb(1'b0, OFS_MAIN_STATUS, 32'h0);
    check(rd[1:0], 32'h0, "result over");
  endtask
  // ---------
  // main sequence
  // ---------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    num_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_regs;
    t_seek(4'hf, 2'h2, 8'h03, 8'h00);
    t_seek(4'he, 2'h2, 8'h01, 8'h03);
    t_read(CMD_READ, 1'b0, 2'h1);
    t_read(CMD_READ, 1'b1, 2'h3);
    t_read(CMD_SCAN, 1'b1, 2'h0);
    conclude;
  end
endmodule // disk_command_parameter_decode_tb
bind disk_command_parameter_decode disk_param_chk #(
  .STEP_UNIT_CYCLES(STEP_UNIT_CYCLES)
) disk_param_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .drive_sel_o(drive_sel_o),
  .step_o(step_o), .dma_req_o(dma_req_o), .data_ready_o(data_ready_o)
);
